// ==== verilog/pci_burst_pkg.sv ====
package pci_burst_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int QW_W = 64;
   localparam int BE_W = 8;
   localparam int CNT_W = 8;
   localparam int ADDR_W = 32;
   localparam int LMS_W = 4;
   localparam int CAUSE_W = 2;

   // ****************************************************************
   // Bus codes and reset values
   // ****************************************************************
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [3:0] CBE_ADDR_HI = 4'h0;
   localparam logic [31:0] AD_ADDR_HI = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [QW_W-1:0] QW_RST = 64'h0000_0000_0000_0000;
   localparam logic [BE_W-1:0] BE_RST = 8'hff;

   // ****************************************************************
   // Local status and end cause codes
   // ****************************************************************
   localparam logic [LMS_W-1:0] LMS_IDLE = 4'h0;
   localparam logic [LMS_W-1:0] LMS_ADDR = 4'h1;
   localparam logic [LMS_W-1:0] LMS_DATA = 4'h2;
   localparam logic [LMS_W-1:0] LMS_BUS_TERM = 4'h3;
   localparam logic [CAUSE_W-1:0] CAUSE_NONE = 2'h0;
   localparam logic [CAUSE_W-1:0] CAUSE_NORMAL = 2'h1;
   localparam logic [CAUSE_W-1:0] CAUSE_ABNORMAL = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_TURN = 4'b1000
   } burst_state_t;

endpackage

// ==== verilog/qw_if.sv ====
interface qw_if;
   import pci_burst_pkg::*;

   logic load;
   logic take;
   logic valid;
   logic [QW_W-1:0] inData;
   logic [BE_W-1:0] inBe;
   logic [QW_W-1:0] outData;
   logic [BE_W-1:0] outBe;

   modport stage (
      input load,
      input take,
      input inData,
      input inBe,
      output valid,
      output outData,
      output outBe
   );

   modport user (
      output load,
      output take,
      output inData,
      output inBe,
      input valid,
      input outData,
      input outBe
   );
endinterface

// ==== verilog/qw_stage.sv ====
module qw_stage (
   input wire logic clk,
   input wire logic rstN,
   input wire logic clkEn,
   qw_if.stage q
);
   import pci_burst_pkg::*;

   logic valid_ff;
   logic [QW_W-1:0] data_ff;
   logic [BE_W-1:0] be_ff;
   logic nxt_valid;

   // ****************************************************************
   // Holding stage
   // ****************************************************************
   // A load in the same cycle as a take refills the stage.
   assign nxt_valid = q.load | (valid_ff & ~q.take);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         valid_ff <= 1'b0;
         data_ff <= QW_RST;
         be_ff <= BE_RST;
      end else if (clkEn) begin
         valid_ff <= nxt_valid;
         if (q.load) begin
            data_ff <= q.inData;
            be_ff <= q.inBe;
         end
      end
   end

   assign q.valid = valid_ff;
   assign q.outData = data_ff;
   assign q.outBe = be_ff;
endmodule

// ==== verilog/pci_master_burst_write_64.sv ====
module pci_master_burst_write_64 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic startReq,
   input wire logic [pci_burst_pkg::CNT_W-1:0] burstLen,
   input wire logic [pci_burst_pkg::ADDR_W-1:0] startAddr,
   input wire logic [pci_burst_pkg::QW_W-1:0] localDataIn,
   input wire logic [pci_burst_pkg::BE_W-1:0] localByteEnableInput,
   input wire logic localSrcReady,
   input wire logic gntN,
   input wire logic devselN,
   input wire logic trdyN,
   input wire logic ack64N,
   output logic lowHalfXferStrobe,
   output logic highHalfXferStrobe,
   output logic [pci_burst_pkg::CNT_W-1:0] remainingBurstCount,
   output logic wideTransferFlag,
   output logic localBusGrant,
   output logic [pci_burst_pkg::LMS_W-1:0] localMasterState,
   output logic [pci_burst_pkg::CAUSE_W-1:0] endCauseCode,
   output logic frameNOut,
   output logic frameOe,
   output logic irdyNOut,
   output logic irdyOe,
   output logic req64NOut,
   output logic req64Oe,
   output logic [pci_burst_pkg::QW_W-1:0] adOut,
   output logic adOe,
   output logic [pci_burst_pkg::BE_W-1:0] cbeOut,
   output logic cbeOe
);
   import pci_burst_pkg::*;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rstSync1_ff;
   logic rstSync2_ff;
   logic rstN;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else if (clkEn) begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   assign rstN = rstSync2_ff;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   burst_state_t state_ff;
   burst_state_t nxt_state;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [CNT_W-1:0] fetchLeft_ff;
   logic [CNT_W-1:0] nxt_fetchLeft;
   logic [CNT_W-1:0] phasesAfter;
   logic strobe_ff;
   logic strobeHi_ff;
   logic nxt_strobe;
   logic adValid_ff;
   logic nxt_adValid;
   logic firstSeen_ff;
   logic nxt_firstSeen;
   logic frameN_ff;
   logic nxt_frameN;
   logic frameOe_ff;
   logic irdyN_ff;
   logic nxt_irdyN;
   logic irdyOe_ff;
   logic req64N_ff;
   logic req64Oe_ff;
   logic [QW_W-1:0] ad_ff;
   logic [QW_W-1:0] nxt_ad;
   logic adOe_ff;
   logic [BE_W-1:0] cbe_ff;
   logic [BE_W-1:0] nxt_cbe;
   logic cbeOe_ff;
   logic wide_ff;
   logic grant_ff;
   logic [LMS_W-1:0] lms_ff;
   logic [LMS_W-1:0] nxt_lms;
   logic [CAUSE_W-1:0] cause_ff;
   logic [CAUSE_W-1:0] nxt_cause;

   logic inIdle;
   logic inAddr;
   logic inData;
   logic inTurn;
   logic startOk;
   logic completed;
   logic lastDone;
   logic adFree;
   logic takeBuf;
   logic devselOk;
   logic irdyOn;
   logic frameOff;
   logic goingData;
   logic bothReady;

   qw_if buf_if ();

   qw_stage u_stage (
      .clk(clk),
      .rstN(rstN),
      .clkEn(clkEn),
      .q(buf_if.stage)
   );

   // ****************************************************************
   // Decode
   // ****************************************************************
   assign inIdle = (state_ff == ST_IDLE);
   assign inAddr = (state_ff == ST_ADDR);
   assign inData = (state_ff == ST_DATA);
   assign inTurn = (state_ff == ST_TURN);
   assign startOk = inIdle & startReq & ~gntN & (burstLen != CNT_ZERO);
   assign bothReady = ~irdyN_ff & ~trdyN;
   assign completed = inData & bothReady;
   assign lastDone = completed & (count_ff == CNT_ONE);
   assign adFree = ~adValid_ff | completed;
   assign takeBuf = inData & adFree & buf_if.valid & ~lastDone;
   assign nxt_adValid = takeBuf | (adValid_ff & ~completed);
   assign devselOk = ~devselN & localSrcReady;
   assign nxt_firstSeen = inData & (firstSeen_ff | (irdyOn & devselOk));
   assign phasesAfter = completed ? count_ff - CNT_ONE : count_ff;
   assign goingData = (nxt_state == ST_DATA);

   // Once the first phase is under way the select is known, so later
   // phases only wait for a loaded quadword.
   assign irdyOn = inData & ~lastDone & nxt_adValid
      & (firstSeen_ff | devselOk);
   assign frameOff = irdyOn & (phasesAfter == CNT_ONE);

   // The local data is captured at the edge that closes a strobe
   // cycle; the master keeps it steady until then.
   assign buf_if.load = strobe_ff;
   assign buf_if.take = takeBuf;
   assign buf_if.inData = localDataIn;
   assign buf_if.inBe = localByteEnableInput;

   // Only one quadword is in flight toward the stage at a time, which
   // halves the fetch rate but never overruns it.
   assign nxt_strobe = goingData & ~lastDone & ~frameOff & ~strobe_ff
      & (fetchLeft_ff != CNT_ZERO) & localSrcReady
      & (~buf_if.valid | takeBuf);

   // ****************************************************************
   // Sequencing
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (startOk) begin
               nxt_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            nxt_state = ST_DATA;
         end
         ST_DATA: begin
            if (lastDone) begin
               nxt_state = ST_TURN;
            end
         end
         ST_TURN: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   assign nxt_count = startOk ? burstLen
      : (inData & lastDone) ? CNT_ZERO
      : completed ? count_ff - CNT_ONE
      : count_ff;
   assign nxt_fetchLeft = startOk ? burstLen
      : strobe_ff ? fetchLeft_ff - CNT_ONE
      : fetchLeft_ff;

   assign nxt_frameN = inAddr ? 1'b0
      : inData ? (frameN_ff | frameOff | lastDone)
      : 1'b1;
   assign nxt_irdyN = ~irdyOn;

   assign nxt_ad = startOk ? {AD_ADDR_HI, startAddr}
      : takeBuf ? buf_if.outData
      : ad_ff;
   assign nxt_cbe = startOk ? {CBE_ADDR_HI, CMD_MEM_WRITE}
      : takeBuf ? buf_if.outBe
      : cbe_ff;

   assign nxt_lms = (nxt_state == ST_ADDR) ? LMS_ADDR
      : goingData ? LMS_DATA
      : (nxt_state == ST_TURN) ? LMS_BUS_TERM
      : LMS_IDLE;
   assign nxt_cause = lastDone ? (bothReady ? CAUSE_NORMAL
      : CAUSE_ABNORMAL)
      : startOk ? CAUSE_NONE
      : cause_ff;

   // ****************************************************************
   // State registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_ff <= ST_IDLE;
         count_ff <= CNT_ZERO;
         fetchLeft_ff <= CNT_ZERO;
         adValid_ff <= 1'b0;
         firstSeen_ff <= 1'b0;
      end else if (clkEn) begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
         fetchLeft_ff <= nxt_fetchLeft;
         adValid_ff <= nxt_adValid & goingData;
         firstSeen_ff <= nxt_firstSeen;
      end
   end

   // ****************************************************************
   // Bus drive registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         frameN_ff <= 1'b1;
         frameOe_ff <= 1'b0;
         irdyN_ff <= 1'b1;
         irdyOe_ff <= 1'b0;
         req64N_ff <= 1'b1;
         req64Oe_ff <= 1'b0;
      end else if (clkEn) begin
         frameN_ff <= nxt_frameN;
         frameOe_ff <= goingData | (nxt_state == ST_ADDR);
         irdyN_ff <= nxt_irdyN;
         irdyOe_ff <= goingData | (nxt_state == ST_TURN);
         req64N_ff <= nxt_frameN;
         req64Oe_ff <= goingData | (nxt_state == ST_ADDR);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ad_ff <= QW_RST;
         adOe_ff <= 1'b0;
         cbe_ff <= BE_RST;
         cbeOe_ff <= 1'b0;
      end else if (clkEn) begin
         ad_ff <= nxt_ad;
         adOe_ff <= goingData | (nxt_state == ST_ADDR);
         cbe_ff <= nxt_cbe;
         cbeOe_ff <= goingData | (nxt_state == ST_ADDR);
      end
   end

   // ****************************************************************
   // Local side registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         strobe_ff <= 1'b0;
         strobeHi_ff <= 1'b0;
         wide_ff <= 1'b0;
         grant_ff <= 1'b0;
         lms_ff <= LMS_IDLE;
         cause_ff <= CAUSE_NONE;
      end else if (clkEn) begin
         strobe_ff <= nxt_strobe;
         strobeHi_ff <= nxt_strobe;
         wide_ff <= goingData & ~ack64N;
         grant_ff <= ~gntN;
         lms_ff <= nxt_lms;
         cause_ff <= nxt_cause;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign lowHalfXferStrobe = strobe_ff;
   assign highHalfXferStrobe = strobeHi_ff;
   assign remainingBurstCount = count_ff;
   assign wideTransferFlag = wide_ff;
   assign localBusGrant = grant_ff;
   assign localMasterState = lms_ff;
   assign endCauseCode = cause_ff;
   assign frameNOut = frameN_ff;
   assign frameOe = frameOe_ff;
   assign irdyNOut = irdyN_ff;
   assign irdyOe = irdyOe_ff;
   assign req64NOut = req64N_ff;
   assign req64Oe = req64Oe_ff;
   assign adOut = ad_ff;
   assign adOe = adOe_ff;
   assign cbeOut = cbe_ff;
   assign cbeOe = cbeOe_ff;
endmodule

// ==== tb/pci_master_burst_write_64_assertions.sv ====
module pci_master_burst_write_64_assertions (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic localSrcReady,
   input wire logic gntN,
   input wire logic devselN,
   input wire logic trdyN,
   input wire logic ack64N,
   input wire logic lowHalfXferStrobe,
   input wire logic highHalfXferStrobe,
   input wire logic [pci_burst_pkg::CNT_W-1:0] remainingBurstCount,
   input wire logic wideTransferFlag,
   input wire logic localBusGrant,
   input wire logic [pci_burst_pkg::LMS_W-1:0] localMasterState,
   input wire logic [pci_burst_pkg::CAUSE_W-1:0] endCauseCode,
   input wire logic frameNOut,
   input wire logic frameOe,
   input wire logic irdyNOut,
   input wire logic irdyOe,
   input wire logic req64NOut,
   input wire logic req64Oe,
   input wire logic adOe,
   input wire logic cbeOe
);
   import pci_burst_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Helper logic
   // ****************************************************************
   // The first ready of a burst is the only one tied to the local ready.
   logic firstPhase_ff;
   wire done = !irdyNOut && irdyOe && !trdyN;
   wire last = done && frameNOut;
   wire nxt_firstPhase = (localMasterState == LMS_ADDR) ? 1'b1 :
                         (irdyNOut ? firstPhase_ff : 1'b0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         firstPhase_ff <= 1'b0;
      end else begin
         firstPhase_ff <= nxt_firstPhase;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_count_step: assert property (
      done |=> remainingBurstCount == $past(remainingBurstCount) - CNT_ONE)
      else $error("burst count did not step down");
   chk_strobe_pair: assert property (
      lowHalfXferStrobe == highHalfXferStrobe and
      (lowHalfXferStrobe |=> !lowHalfXferStrobe))
      else $error("strobe pair broken");
   chk_first_ready: assert property (
      $fell(irdyNOut) && firstPhase_ff |-> $past(localSrcReady && !devselN))
      else $error("initiator ready without select and local ready");
   chk_frame_hold: assert property (
      frameOe && !frameNOut && irdyNOut |=> !frameNOut || !irdyNOut)
      else $error("frame dropped during wait");
   chk_last_phase: assert property (
      $rose(frameNOut) && frameOe |-> !irdyNOut && req64NOut &&
      !lowHalfXferStrobe) else $error("last phase signals wrong");
   chk_turn_release: assert property (
      last |=> !frameOe && !req64Oe && !adOe && !cbeOe && irdyNOut &&
      remainingBurstCount == CNT_ZERO) else $error("turnaround not clean");
   chk_turn_status: assert property (
      last |=> localMasterState == LMS_BUS_TERM &&
      endCauseCode == CAUSE_NORMAL) else $error("turnaround status wrong");
   chk_wide_flag: assert property (
      !irdyNOut && irdyOe && $past(!ack64N) |-> wideTransferFlag)
      else $error("wide flag missing");
   chk_grant_follow: assert property (
      1'b1 |=> localBusGrant == !$past(gntN))
      else $error("local grant does not follow bus grant");

   cover property (last);
   cover property (done && !frameNOut);
   cover property (frameOe && !frameNOut && irdyNOut && !devselN);
endmodule

bind pci_master_burst_write_64 pci_master_burst_write_64_assertions
   u_pci_master_burst_write_64_assertions (.clk, .rst_n, .localSrcReady,
   .gntN, .devselN, .trdyN, .ack64N, .lowHalfXferStrobe,
   .highHalfXferStrobe, .remainingBurstCount, .wideTransferFlag,
   .localBusGrant, .localMasterState, .endCauseCode, .frameNOut, .frameOe,
   .irdyNOut, .irdyOe, .req64NOut, .req64Oe, .adOe, .cbeOe);

// ==== tb/pci_target_model.sv ====
module pci_target_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic frameNOut,
   input wire logic frameOe,
   input wire logic irdyNOut,
   input wire logic irdyOe,
   input wire logic req64NOut,
   input wire logic [63:0] adOut,
   input wire logic [7:0] cbeOut,
   output logic devselN,
   output logic trdyN,
   output logic ack64N
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************************************
   // Target
   // ****************************************************************
   // Released lines carry pull-ups, so letting go reads back as high.
   logic act;
   logic [71:0] got[$];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act <= 1'b0;
         {devselN, trdyN, ack64N} <= 3'h7;
      end else if (!act && frameOe && !frameNOut) begin
         act <= 1'b1;
         devselN <= 1'b0;
         ack64N <= req64NOut;
         trdyN <= slow;
      end else if (act && !irdyNOut && irdyOe && !trdyN) begin
         got.push_back({cbeOut, adOut});
         trdyN <= slow;
         if (frameNOut) begin
            act <= 1'b0;
            {devselN, trdyN, ack64N} <= 3'h7;
         end
      end else if (act) begin
         trdyN <= 1'b0;
      end
   end
endmodule

// ==== tb/pci_master_burst_write_64_bench.sv ====
module pci_master_burst_write_64_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import pci_burst_pkg::*;

   logic clk = 1'b0, rst_n = 1'b0, startReq = 1'b0, gntN = 1'b1;
   logic localSrcReady = 1'b0, stall = 1'b0, slow = 1'b0;
   logic [CNT_W-1:0] burstLen = CNT_ZERO;
   logic [ADDR_W-1:0] startAddr = 32'h0000_0000;
   logic [QW_W-1:0] localDataIn = QW_RST;
   logic [BE_W-1:0] localByteEnableInput = BE_RST;
   logic devselN, trdyN, ack64N, lowHalfXferStrobe, wideTransferFlag;
   logic localBusGrant, frameNOut, frameOe, irdyNOut, irdyOe, req64NOut;
   logic [CNT_W-1:0] remainingBurstCount;
   logic [LMS_W-1:0] localMasterState;
   logic [CAUSE_W-1:0] endCauseCode;
   logic [QW_W-1:0] adOut;
   logic [BE_W-1:0] cbeOut;
   int err_total = 0, comparisons = 0, cycles = 0, idx = 0, strobeCnt = 0;

   pci_master_burst_write_64 u_pci_master_burst_write_64 (.clk, .rst_n,
      .clkEn(1'b1), .startReq, .burstLen, .startAddr, .localDataIn,
      .localByteEnableInput, .localSrcReady, .gntN, .devselN, .trdyN,
      .ack64N, .lowHalfXferStrobe, .highHalfXferStrobe(),
      .remainingBurstCount, .wideTransferFlag, .localBusGrant,
      .localMasterState, .endCauseCode, .frameNOut, .frameOe, .irdyNOut,
      .irdyOe, .req64NOut, .req64Oe(), .adOut, .adOe(), .cbeOut, .cbeOe());

   pci_target_model u_pci_target_model (.clk, .rst_n, .slow, .frameNOut,
      .frameOe, .irdyNOut, .irdyOe, .req64NOut, .adOut, .cbeOut, .devselN,
      .trdyN, .ack64N);

   // ****************************************************************
   // Local master and run control
   // ****************************************************************
   always #50 clk = ~clk;

   function automatic logic [71:0] beat(input int i);
      beat = {8'(i) ^ 8'h3c, 32'ha5a5_0000 | 32'(i), ~32'(i)};
   endfunction

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (lowHalfXferStrobe === 1'b1) begin
         idx <= idx + 1;
         {localByteEnableInput, localDataIn} <= beat(idx + 1);
         strobeCnt <= strobeCnt + 1;
      end
      localSrcReady <= stall ? ~localSrcReady : 1'b1;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end

   task automatic cmp_val(input logic [71:0] got, input logic [71:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_val({71'h0, got}, {71'h0, exp});
   endtask

   task automatic stop_test();
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // A zero length or a missing grant must leave the block idle.
   task automatic grant_check();
      @(posedge clk);
      burstLen <= 8'h02;
      startReq <= 1'b1;
      repeat (4) @(posedge clk);
      cmp_val(72'(localMasterState), 72'(LMS_IDLE));
      cmp_bit(localBusGrant, 1'b0);
      gntN <= 1'b0;
      burstLen <= CNT_ZERO;
      repeat (2) @(posedge clk);
      cmp_bit(localBusGrant, 1'b1);
      repeat (2) @(posedge clk);
      cmp_val(72'(localMasterState), 72'(LMS_IDLE));
      gntN <= 1'b1;
      startReq <= 1'b0;
      repeat (2) @(posedge clk);
      cmp_bit(localBusGrant, 1'b0);
   endtask

   task automatic run_burst(input int len, input logic slw, input logic stl);
      int n;
      logic w;
      n = 0;
      w = 1'b0;
      @(posedge clk);
      slow <= slw;
      stall <= stl;
      gntN <= 1'b0;
      idx <= 0;
      strobeCnt <= 0;
      {localByteEnableInput, localDataIn} <= beat(0);
      u_pci_target_model.got.delete();
      burstLen <= 8'(len);
      startAddr <= 32'h0000_1000 + 32'(len);
      startReq <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (localMasterState !== LMS_ADDR && n < 20);
      startReq <= 1'b0;
      while (localMasterState !== LMS_BUS_TERM && n < 2000) begin
         @(posedge clk);
         n++;
         if (irdyNOut === 1'b0) w = wideTransferFlag;
      end
      cmp_bit(w, 1'b1);
      cmp_val(72'(localMasterState), 72'(LMS_BUS_TERM));
      cmp_val(72'(endCauseCode), 72'(CAUSE_NORMAL));
      cmp_val(72'(remainingBurstCount), 72'(CNT_ZERO));
      cmp_val(72'(strobeCnt), 72'(len));
      cmp_val(72'(u_pci_target_model.got.size()), 72'(len));
      for (int i = 0; i < len; i++) begin
         cmp_val(u_pci_target_model.got[i], beat(i));
      end
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      grant_check();
      run_burst(1, 1'b0, 1'b0);
      run_burst(4, 1'b0, 1'b0);
      run_burst(3, 1'b1, 1'b0);
      run_burst(5, 1'b0, 1'b1);
      run_burst(6, 1'b1, 1'b1);
      run_burst(255, 1'b0, 1'b0);
      stop_test();
   end
endmodule
